// file: src/csd_io_select_decoder.sv
// Purpose: Select decoder for the board's bit-serial I/O space, with the local bits.
// Assumes: Inputs synchronous to SYS_CLK; a bit access holds its address for the cycle.
// Notes: Every output is registered, so each one trails its inputs by one clock.
//
// What this block does
// R1: Decode A3..A9 into eight block selects, 32 bit addresses each.
// R2: Block select 3 is reserved and never asserts.
// R3: Internal flag comes from A3..A6 and memory-cycle enable only.
// R4: On-board address enables block selects and disables the external buffer.
// R5: Off-board address keeps buffer enabled and all block selects inactive.
// R6: Off-board devices inside on-board space are ignored; map is fixed.
// R7: A0, A1 and A2 never affect decode.
// R8: Output strobe suppressed during external-instruction cycles.
// R9: Status indicator at 0000, aliased across 0001..001F.
// R10: Unit switch at 0020..0024 read-only, 0025..0027 zero, aliases to 003F.
// R11: Local serial at 0040..005F, parallel/timer at 0080..009F split in halves.
// R12: Interrupt-6 latch clear at 00A6, aliased across 00A0..00BF.
// R13: Remote serial selected for 00C0..00DF.
// R14: Modem bits at 00E0..00E2, inputs repeat every four, output across block.
// R15: From 0100 upward everything is off-board.
// R16: Partly decoded devices answer identically at alias addresses.
// R17: Software uses only nominal addresses, never aliases.
// R18: Block selects active low, at most one active at a time.
// R19: External bit lines disabled during on-board bit accesses.
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_io_select_decoder (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Processor bit-serial side
    input wire logic [11:0] BIT_ADDR,
    input wire logic MEMORY_CYCLE_ENABLE_N,
    input wire logic BIT_OUTPUT_STROBE,
    input wire logic EXT_INSTR_CYCLE,
    input wire logic CPU_BIT_OUT,
    output logic CPU_BIT_IN,
    // On-board peripherals
    input wire logic PERIPH_BIT_IN,
    output logic [7:0] ONBOARD_BLOCK_SELECT_N,
    output logic PARALLEL_HALF_SEL,
    output logic GATED_BIT_OUTPUT_STROBE,
    // Off-board expansion buffer
    input wire logic BUFFERED_BIT_IN,
    output logic BUFFERED_BIT_OUT,
    output logic BUFFER_ENABLE,
    output logic INTERNAL_SPACE_FLAG,
    // Local bits
    input wire logic [4:0] UNIT_SWITCH,
    input wire logic MODEM_SET_READY,
    input wire logic MODEM_RING_IND,
    output logic STATUS_INDICATOR,
    output logic EXTERNAL_IRQ_SIX_CLEAR,
    output logic MODEM_TERM_READY
);

    csd_pkg::csd_decode_t dec;
    wire strobe_ok;
    wire local_rd_bit;
    wire local_rd_own;
    wire bit_in_nxt;
    logic [7:0] sel_n_r;
    logic internal_r;
    logic buf_en_r;
    logic buf_out_r;
    logic strobe_r;
    logic bit_in_r;
    logic half_r;
    logic status_r;
    logic term_ready_r;
    logic irq6_clear_r;

    csd_block_decode u_decode (
        .bit_addr(BIT_ADDR),
        .memory_cycle_enable_n(MEMORY_CYCLE_ENABLE_N),
        .dec(dec)
    );

    // Output strobe never reaches any device during an external instruction
    assign strobe_ok = BIT_OUTPUT_STROBE && !EXT_INSTR_CYCLE; // R8

    csd_local_bits u_local (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .dec(dec),
        .strobe(strobe_ok),
        .bit_out(CPU_BIT_OUT),
        .unit_switch(UNIT_SWITCH),
        .modem_set_ready(MODEM_SET_READY),
        .modem_ring(MODEM_RING_IND),
        .status_r(status_r),
        .term_ready_r(term_ready_r),
        .irq6_clear_r(irq6_clear_r),
        .rd_bit(local_rd_bit),
        .rd_own(local_rd_own)
    );

    // Off-board answers inside on-board space never reach the processor
    assign bit_in_nxt = dec.internal ? (local_rd_own ? local_rd_bit : PERIPH_BIT_IN)
        : BUFFERED_BIT_IN; // R6

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel_n_r <= `CSD_ALL_DESELECTED;
            internal_r <= 1'h0;
            buf_en_r <= 1'h1;
            buf_out_r <= 1'h0;
            strobe_r <= 1'h0;
            bit_in_r <= 1'h0;
            half_r <= 1'h0;
        end else begin
            sel_n_r <= dec.sel_n; // R1 R11 R13 R18
            internal_r <= dec.internal; // R3
            buf_en_r <= !dec.internal; // R4 R5 R19
            // Held low while the buffer is off so no edge leaks to the expansion bus
            buf_out_r <= dec.internal ? 1'h0 : CPU_BIT_OUT; // R19
            strobe_r <= strobe_ok; // R8
            bit_in_r <= bit_in_nxt;
            half_r <= dec.offset[`CSD_HALF_BIT]; // R11
        end
    end

    assign ONBOARD_BLOCK_SELECT_N = sel_n_r;
    assign INTERNAL_SPACE_FLAG = internal_r;
    assign BUFFER_ENABLE = buf_en_r;
    assign BUFFERED_BIT_OUT = buf_out_r;
    assign GATED_BIT_OUTPUT_STROBE = strobe_r;
    assign CPU_BIT_IN = bit_in_r;
    assign PARALLEL_HALF_SEL = half_r;
    assign STATUS_INDICATOR = status_r;
    assign EXTERNAL_IRQ_SIX_CLEAR = irq6_clear_r;
    assign MODEM_TERM_READY = term_ready_r;

    // Helper terms watched only by the checks below
    wire [2:0] chk_blk;
    wire [7:0] chk_unit_ext;
    wire chk_onboard;
    wire chk_wr;
    wire chk_wr_status;
    wire chk_wr_irq6;
    wire chk_wr_modem;
    wire chk_rd_unit_ground;
    wire chk_periph_blk;
    logic chk_live_r;
    assign chk_blk = BIT_ADDR[`CSD_BLOCK_MSB:`CSD_BLOCK_LSB];
    assign chk_unit_ext = {3'h0, UNIT_SWITCH};
    assign chk_onboard = (BIT_ADDR[`CSD_SPACE_MSB:`CSD_SPACE_LSB] == `CSD_ONBOARD_SPACE)
        && MEMORY_CYCLE_ENABLE_N;
    assign chk_wr = BIT_OUTPUT_STROBE && !EXT_INSTR_CYCLE && chk_onboard;
    assign chk_wr_status = chk_wr && (chk_blk == csd_pkg::BLK_STATUS);
    assign chk_wr_irq6 = chk_wr && (chk_blk == csd_pkg::BLK_IRQ6_CLEAR);
    assign chk_wr_modem = chk_wr && (chk_blk == csd_pkg::BLK_MODEM);
    assign chk_rd_unit_ground = chk_onboard && (chk_blk == csd_pkg::BLK_UNIT_SWITCH)
        && (BIT_ADDR[2:0] > `CSD_UNIT_LAST);
    assign chk_periph_blk = (chk_blk == csd_pkg::BLK_LOCAL_SERIAL)
        || (chk_blk == csd_pkg::BLK_RESERVED) || (chk_blk == csd_pkg::BLK_PARALLEL_TIMER)
        || (chk_blk == csd_pkg::BLK_REMOTE_SERIAL);

    // Checks start one clock after release: the release edge itself still resets
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            chk_live_r <= 1'h0;
        end else begin
            chk_live_r <= 1'h1;
        end
    end

    property p_block_map;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && (chk_blk != csd_pkg::BLK_RESERVED)
        |=> !ONBOARD_BLOCK_SELECT_N[$past(chk_blk)];
    endproperty
    a_block_map: assert property (p_block_map) // R1
        else $error("on-board block select missing for decoded block");

    property p_reserved;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard |=> ONBOARD_BLOCK_SELECT_N[csd_pkg::BLK_RESERVED];
    endproperty
    a_reserved: assert property (p_reserved) // R2
        else $error("reserved block select asserted");

    property p_flag;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        ##1 INTERNAL_SPACE_FLAG == $past(chk_onboard);
    endproperty
    a_flag: assert property (p_flag) // R3
        else $error("internal space flag does not follow address and memory enable");

    property p_onboard_buffer;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard |=> !BUFFER_ENABLE && !BUFFERED_BIT_OUT && INTERNAL_SPACE_FLAG;
    endproperty
    a_onboard_buffer: assert property (p_onboard_buffer) // R4
        else $error("external buffer active during on-board access");

    property p_offboard;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        !chk_onboard |=> BUFFER_ENABLE && (ONBOARD_BLOCK_SELECT_N == `CSD_ALL_DESELECTED)
            && (CPU_BIT_IN == $past(BUFFERED_BIT_IN))
            && (BUFFERED_BIT_OUT == $past(CPU_BIT_OUT));
    endproperty
    a_offboard: assert property (p_offboard) // R5
        else $error("off-board access not passed through the buffer");

    property p_ignore_external;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && chk_periph_blk
        |=> !BUFFER_ENABLE && (CPU_BIT_IN == $past(PERIPH_BIT_IN));
    endproperty
    a_ignore_external: assert property (p_ignore_external) // R6 R11 R13
        else $error("external bit-in reached the processor in on-board space");

    property p_high_lines;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && (chk_blk == csd_pkg::BLK_STATUS)
        |=> !ONBOARD_BLOCK_SELECT_N[csd_pkg::BLK_STATUS] && $onehot(~ONBOARD_BLOCK_SELECT_N);
    endproperty
    a_high_lines: assert property (p_high_lines) // R7
        else $error("block zero decode disturbed");

    property p_ext_instr;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        EXT_INSTR_CYCLE |=> !GATED_BIT_OUTPUT_STROBE && $stable(STATUS_INDICATOR)
            && $stable(MODEM_TERM_READY) && !EXTERNAL_IRQ_SIX_CLEAR;
    endproperty
    a_ext_instr: assert property (p_ext_instr) // R8
        else $error("bit output took effect during an external instruction");

    property p_status;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_wr_status |=> STATUS_INDICATOR == $past(CPU_BIT_OUT);
    endproperty
    a_status: assert property (p_status) // R9
        else $error("status indicator not written at its address or alias");

    property p_unit_ground;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_rd_unit_ground |=> !CPU_BIT_IN;
    endproperty
    a_unit_ground: assert property (p_unit_ground) // R10
        else $error("grounded switch positions read as one");

    property p_half;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && (chk_blk == csd_pkg::BLK_PARALLEL_TIMER)
        |=> !ONBOARD_BLOCK_SELECT_N[csd_pkg::BLK_PARALLEL_TIMER]
            && (PARALLEL_HALF_SEL == $past(BIT_ADDR[`CSD_HALF_BIT]));
    endproperty
    a_half: assert property (p_half) // R11
        else $error("parallel/timer select or half indication wrong");

    property p_irq6;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_wr_irq6 ##1 !chk_wr_irq6 |-> EXTERNAL_IRQ_SIX_CLEAR ##1 !EXTERNAL_IRQ_SIX_CLEAR;
    endproperty
    a_irq6: assert property (p_irq6) // R12
        else $error("interrupt-6 clear is not a single-cycle pulse");

    property p_modem;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_wr_modem |=> MODEM_TERM_READY == $past(CPU_BIT_OUT);
    endproperty
    a_modem: assert property (p_modem) // R14
        else $error("terminal-ready output not written across the modem block");

    property p_onehot;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        $onehot0(~ONBOARD_BLOCK_SELECT_N);
    endproperty
    a_onehot: assert property (p_onehot) // R18
        else $error("more than one block select active");

    property p_offboard_space;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        (BIT_ADDR[`CSD_SPACE_MSB:`CSD_SPACE_LSB] != `CSD_ONBOARD_SPACE)
        |=> !INTERNAL_SPACE_FLAG && $stable(STATUS_INDICATOR) && $stable(MODEM_TERM_READY)
            && !EXTERNAL_IRQ_SIX_CLEAR;
    endproperty
    a_offboard_space: assert property (p_offboard_space) // R15
        else $error("access above on-board space reached a local bit");

    property p_unit_read;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && (chk_blk == csd_pkg::BLK_UNIT_SWITCH)
        |=> CPU_BIT_IN == $past(chk_unit_ext[BIT_ADDR[2:0]]);
    endproperty
    a_unit_read: assert property (p_unit_read) // R10 R16
        else $error("switch position read back wrong");

    property p_modem_dsr;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && (chk_blk == csd_pkg::BLK_MODEM)
            && (BIT_ADDR[1:0] == `CSD_MODEM_SET_READY) |=> CPU_BIT_IN == $past(MODEM_SET_READY);
    endproperty
    a_modem_dsr: assert property (p_modem_dsr) // R14 R16
        else $error("set-ready input not returned at its address or alias");

    property p_modem_ring;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        chk_onboard && (chk_blk == csd_pkg::BLK_MODEM)
            && (BIT_ADDR[1:0] == `CSD_MODEM_RING) |=> CPU_BIT_IN == $past(MODEM_RING_IND);
    endproperty
    a_modem_ring: assert property (p_modem_ring) // R14 R16
        else $error("ring input not returned at its address or alias");

    property p_strobe;
        @(posedge SYS_CLK) disable iff (!RSTN || !chk_live_r)
        BIT_OUTPUT_STROBE && !EXT_INSTR_CYCLE |=> GATED_BIT_OUTPUT_STROBE;
    endproperty
    a_strobe: assert property (p_strobe) // R8
        else $error("output strobe lost outside external instructions");

endmodule

// file: src/csd_params.svh
// Purpose: Named constants for the bit-serial I/O select decoder.
// Assumes: Bit address is processor address lines A3..A14, A3 as the MSB.
// Notes: Definitions only.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// Field layout of the 12-bit bit address
`define CSD_SPACE_MSB 11
`define CSD_SPACE_LSB 8
`define CSD_BLOCK_MSB 7
`define CSD_BLOCK_LSB 5
`define CSD_OFFSET_MSB 4
`define CSD_HALF_BIT 4
`define CSD_ONBOARD_SPACE 4'h0
`define CSD_ALL_DESELECTED 8'hFF

// Nominal bit addresses of the local bits
`define CSD_ADDR_STATUS 12'h000
`define CSD_ADDR_UNIT 12'h020
`define CSD_ADDR_IRQ6_CLEAR 12'h0A6
`define CSD_ADDR_MODEM 12'h0E0

// Offsets inside the switch group and the modem group
`define CSD_UNIT_LAST 3'h4
`define CSD_MODEM_TERM_READY 2'h0
`define CSD_MODEM_SET_READY 2'h1
`define CSD_MODEM_RING 2'h2

// Reset values
`define CSD_STATUS_RST 1'h0
`define CSD_TERM_READY_RST 1'h0

`endif

// file: src/csd_pkg.sv
// Purpose: Types shared by the bit-serial I/O select decoder.
// Assumes: Nothing beyond the params header.
// Notes: Block order follows the on-board map, one 32-bit block each.
package csd_pkg;

    typedef enum logic [2:0] {
        BLK_STATUS,
        BLK_UNIT_SWITCH,
        BLK_LOCAL_SERIAL,
        BLK_RESERVED,
        BLK_PARALLEL_TIMER,
        BLK_IRQ6_CLEAR,
        BLK_REMOTE_SERIAL,
        BLK_MODEM
    } csd_block_t;

    typedef struct packed {
        logic internal;
        csd_block_t block;
        logic [4:0] offset;
        logic [7:0] sel_n;
    } csd_decode_t;

endpackage

// file: src/csd_block_decode.sv
// Purpose: Combinational decode of a bit address into block selects.
// Assumes: Only A3..A14 reach this module.
// Notes: Address lines A0..A2 are not wired in at all.
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_block_decode (
    // Address side
    input wire logic [11:0] bit_addr,
    input wire logic memory_cycle_enable_n,
    // Decode result
    output csd_pkg::csd_decode_t dec
);

    wire in_space;
    wire [2:0] blk;
    logic [7:0] sel_n;

    // Memory cycles never decode as bit-serial accesses
    assign in_space = (bit_addr[`CSD_SPACE_MSB:`CSD_SPACE_LSB] == `CSD_ONBOARD_SPACE)
        && memory_cycle_enable_n; // R3 R15
    assign blk = bit_addr[`CSD_BLOCK_MSB:`CSD_BLOCK_LSB]; // R1 R7

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sel
            if (gi == csd_pkg::BLK_RESERVED) begin : g_res
                assign sel_n[gi] = 1'h1; // R2
            end else begin : g_act
                assign sel_n[gi] = ~(in_space && (blk == 3'(gi))); // R1 R18
            end
        end
    endgenerate

    assign dec.internal = in_space;
    assign dec.block = csd_pkg::csd_block_t'(blk);
    assign dec.offset = bit_addr[`CSD_OFFSET_MSB:0];
    assign dec.sel_n = sel_n;

endmodule

// file: src/csd_local_bits.sv
// Purpose: Status indicator, unit switch, interrupt-6 clear and modem bits.
// Assumes: Strobe arrives already gated for external-instruction cycles.
// Notes: Partial decode is deliberate, so every alias answers like the nominal bit.
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_local_bits (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Access
    input csd_pkg::csd_decode_t dec,
    input wire logic strobe,
    input wire logic bit_out,
    // Board inputs
    input wire logic [4:0] unit_switch,
    input wire logic modem_set_ready,
    input wire logic modem_ring,
    // Results
    output logic status_r,
    output logic term_ready_r,
    output logic irq6_clear_r,
    output logic rd_bit,
    output logic rd_own
);

    wire wr;
    wire in_status;
    wire in_unit;
    wire in_irq6;
    wire in_modem;
    wire unit_bit;
    wire modem_bit;
    wire [2:0] unit_idx;
    wire [1:0] modem_idx;
    wire [7:0] unit_ext;

    assign wr = strobe && dec.internal;
    assign in_status = dec.block == csd_pkg::BLK_STATUS;
    assign in_unit = dec.block == csd_pkg::BLK_UNIT_SWITCH;
    assign in_irq6 = dec.block == csd_pkg::BLK_IRQ6_CLEAR;
    assign in_modem = dec.block == csd_pkg::BLK_MODEM;
    assign unit_idx = dec.offset[2:0]; // R10 R16
    assign modem_idx = dec.offset[1:0]; // R14 R16

    // Upper three switch positions are grounded; padding keeps the index in range
    assign unit_ext = {3'h0, unit_switch};
    assign unit_bit = (unit_idx <= `CSD_UNIT_LAST) ? unit_ext[unit_idx] : 1'h0; // R10
    assign modem_bit = (modem_idx == `CSD_MODEM_TERM_READY) ? term_ready_r :
        (modem_idx == `CSD_MODEM_SET_READY) ? modem_set_ready :
        (modem_idx == `CSD_MODEM_RING) ? modem_ring : 1'h0; // R14

    assign rd_own = dec.internal && (in_status || in_unit || in_irq6 || in_modem);
    assign rd_bit = in_unit ? unit_bit : (in_modem ? modem_bit : 1'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= `CSD_STATUS_RST;
            term_ready_r <= `CSD_TERM_READY_RST;
            irq6_clear_r <= 1'h0;
        end else begin
            if (wr && in_status) begin
                status_r <= bit_out; // R9
            end
            if (wr && in_modem) begin
                term_ready_r <= bit_out; // R14
            end
            irq6_clear_r <= wr && in_irq6; // R12
        end
    end

endmodule

// file: dv/csd_far_side_model.sv
// Purpose: Far side of the select decoder: on-board peripherals and off-board device.
// Assumes: Answers are driven from the address the processor presents.
// Notes: A line that nobody drives wanders every cycle, so it cannot pass as an answer.
`timescale 1ns/1ps

module csd_far_side_model (
    // Clock
    input wire logic clk,
    // Processor side
    input wire logic [11:0] bit_addr,
    input wire logic mem_n,
    // Answers
    output logic periph_bit,
    output logic buf_bit
);
    logic tog = 1'h0;
    wire onb = (bit_addr[11:8] == 4'h0) && mem_n;
    wire [2:0] blk = bit_addr[7:5];
    wire periph_hit = onb && (blk == 3'h2 || blk == 3'h3 || blk == 3'h4 || blk == 3'h6);

    always @(posedge clk) begin
        tog <= ~tog;
    end

    assign periph_bit = periph_hit ? ^bit_addr[4:0] : tog;
    // Off-board device stays off on-board addresses, leaving a wandering level
    assign buf_bit = onb ? ~tog : (bit_addr[0] ^ bit_addr[7]);
endmodule

// file: dv/test_csd_io_select_decoder.sv
// Purpose: Self-checking bench for the bit-serial I/O select decoder.
// Assumes: All outputs trail the sampled inputs by one clock.
// Notes: Software-style accesses use nominal addresses except where aliases are tested.
`timescale 1ns/1ps

module test_csd_io_select_decoder;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic [11:0] addr = 12'h000;
    logic mem_n = 1'h1;
    logic stb = 1'h0;
    logic ext = 1'h0;
    logic dout = 1'h0;
    logic [4:0] unit = 5'h15;
    logic dsr = 1'h1;
    logic ri = 1'h0;
    wire periph_bit, buf_bit, cpu_in, half, gstb, bbo, buf_en, flag, status, irq_clr, dtr;
    wire [7:0] sel_n;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    csd_io_select_decoder DUT (
        .SYS_CLK(sys_clk), .RSTN(rstn), .BIT_ADDR(addr), .MEMORY_CYCLE_ENABLE_N(mem_n),
        .BIT_OUTPUT_STROBE(stb), .EXT_INSTR_CYCLE(ext), .CPU_BIT_OUT(dout),
        .CPU_BIT_IN(cpu_in), .PERIPH_BIT_IN(periph_bit), .ONBOARD_BLOCK_SELECT_N(sel_n),
        .PARALLEL_HALF_SEL(half), .GATED_BIT_OUTPUT_STROBE(gstb),
        .BUFFERED_BIT_IN(buf_bit), .BUFFERED_BIT_OUT(bbo), .BUFFER_ENABLE(buf_en),
        .INTERNAL_SPACE_FLAG(flag), .UNIT_SWITCH(unit), .MODEM_SET_READY(dsr),
        .MODEM_RING_IND(ri), .STATUS_INDICATOR(status),
        .EXTERNAL_IRQ_SIX_CLEAR(irq_clr), .MODEM_TERM_READY(dtr)
    );

    csd_far_side_model far_side (
        .clk(sys_clk), .bit_addr(addr), .mem_n(mem_n),
        .periph_bit(periph_bit), .buf_bit(buf_bit)
    );

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("Checked %0d samples, %0d errors", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access; strobe drops at the sampling edge so a write never repeats
    task automatic acc(input logic [11:0] a, input logic s, input logic x, input logic d);
        @(posedge sys_clk);
        addr <= a;
        mem_n <= 1'h1;
        stb <= s;
        ext <= x;
        dout <= d;
        @(posedge sys_clk);
        stb <= 1'h0;
        ext <= 1'h0;
        #1;
    endtask

    task automatic look(input logic [7:0] es, input logic ef);
        chk("select", es, sel_n);
        chk("flag", {7'h00, ef}, {7'h00, flag});
        chk("buffer enable", {7'h00, ~ef}, {7'h00, buf_en});
    endtask

    task automatic t_blocks();
        for (int b = 0; b < 8; b++) begin
            for (int o = 0; o < 32; o += 31) begin
                acc({4'h0, 3'(b), 5'(o)}, 1'h0, 1'h0, 1'h1);
                look((b == 3) ? 8'hFF : ~(8'h01 << b), 1'h1);
                chk("bit out", 8'h00, {7'h00, bbo});
            end
        end
        @(posedge sys_clk);
        addr <= 12'h000;
        mem_n <= 1'h0;
        @(posedge sys_clk);
        #1;
        look(8'hFF, 1'h0);
    endtask

    task automatic t_offboard();
        logic [11:0] list [3] = '{12'h100, 12'h101, 12'hF7F};
        foreach (list[i]) begin
            acc(list[i], 1'h1, 1'h0, 1'h1);
            look(8'hFF, 1'h0);
            chk("bit out", 8'h01, {7'h00, bbo});
            chk("bit in", {7'h00, list[i][0] ^ list[i][7]}, {7'h00, cpu_in});
            chk("strobe", 8'h01, {7'h00, gstb});
            chk("status", 8'h00, {7'h00, status});
        end
    endtask

    task automatic t_status();
        acc(12'h000, 1'h1, 1'h0, 1'h1);
        chk("status", 8'h01, {7'h00, status});
        acc(12'h01F, 1'h1, 1'h1, 1'h0);
        chk("status", 8'h01, {7'h00, status});
        chk("strobe", 8'h00, {7'h00, gstb});
        acc(12'h01F, 1'h1, 1'h0, 1'h0);
        chk("status", 8'h00, {7'h00, status});
        acc(12'h013, 1'h1, 1'h0, 1'h1);
        chk("status", 8'h01, {7'h00, status});
        acc(12'h000, 1'h0, 1'h0, 1'h0);
        chk("status", 8'h01, {7'h00, status});
    endtask

    task automatic t_switch();
        for (int i = 0; i < 32; i++) begin
            acc(12'h020 + 12'(i), 1'h0, 1'h0, 1'h0);
            chk("switch", {7'h00, (i % 8 < 5) ? unit[i % 8] : 1'h0}, {7'h00, cpu_in});
        end
    endtask

    task automatic t_irq6();
        acc(12'h0A6, 1'h1, 1'h0, 1'h0);
        chk("irq6 clear", 8'h01, {7'h00, irq_clr});
        @(posedge sys_clk);
        #1;
        chk("irq6 clear", 8'h00, {7'h00, irq_clr});
        acc(12'h0BF, 1'h1, 1'h0, 1'h1);
        chk("irq6 clear", 8'h01, {7'h00, irq_clr});
        acc(12'h0A0, 1'h1, 1'h1, 1'h1);
        chk("irq6 clear", 8'h00, {7'h00, irq_clr});
    endtask

    task automatic t_modem();
        acc(12'h0E0, 1'h1, 1'h0, 1'h1);
        chk("term ready", 8'h01, {7'h00, dtr});
        acc(12'h0E0, 1'h0, 1'h0, 1'h0);
        chk("term ready read", 8'h01, {7'h00, cpu_in});
        acc(12'h0FF, 1'h1, 1'h0, 1'h0);
        chk("term ready", 8'h00, {7'h00, dtr});
        for (int i = 0; i < 32; i++) begin
            acc(12'h0E0 + 12'(i), 1'h0, 1'h0, 1'h0);
            chk("modem", {7'h00, (i % 4 == 1) ? dsr : (i % 4 == 2) ? ri : 1'h0},
                {7'h00, cpu_in});
        end
        @(posedge sys_clk);
        ri <= 1'h1;
        acc(12'h0FE, 1'h0, 1'h0, 1'h0);
        chk("modem", 8'h01, {7'h00, cpu_in});
    endtask

    task automatic t_periph();
        logic [11:0] list [4] = '{12'h041, 12'h08F, 12'h090, 12'h0DE};
        foreach (list[i]) begin
            acc(list[i], 1'h0, 1'h0, 1'h0);
            chk("periph bit", {7'h00, ^list[i][4:0]}, {7'h00, cpu_in});
            chk("half", {7'h00, list[i][4]}, {7'h00, half});
        end
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        look(8'hFF, 1'h0);
        @(posedge sys_clk);
        rstn <= 1'h1;
        t_blocks();
        t_offboard();
        t_status();
        t_switch();
        t_irq6();
        t_modem();
        t_periph();
        end_of_test();
    end
endmodule
